// file: hdl/line_write_port.sv
// Serial line-write port with panel memory and polarity inversion control
`timescale 1ns/10ps
module line_write_port #(
  parameter int PIXELS = line_write_pkg::LINE_PIXELS,
  parameter int LINES = line_write_pkg::LINE_COUNT
) (
  // System side
  input wire logic clk,
  input wire logic reset,
  // Serial link
  input wire logic sclk,
  input wire logic chip_select_high,
  input wire logic serial_data_in,
  // Inversion pins
  input wire logic inversion_source_select,
  input wire logic external_inversion_toggle,
  // Panel scan read port
  input wire logic [7:0] rd_line,
  output logic [PIXELS-1:0] rd_pixels,
  // Status and panel drive
  output logic updating_mode,
  output logic clear_busy,
  output logic clear_done,
  output logic panel_inversion_level,
  output logic internal_inversion_signal
);

  // Link domain
  // Counters restart whenever chip select is low, so a stopped clock
  // outside frames leaves nothing half done.
  logic link_rst;
  assign link_rst = reset | ~chip_select_high;

  logic hdr_done_reg;
  logic [7:0] bit_cnt_reg;
  logic [7:0] addr_sh_reg;
  logic [PIXELS-1:0] pix_sh_reg;
  logic hdr_end;
  logic line_end;

  assign hdr_end = !hdr_done_reg &&
                   bit_cnt_reg == 8'(line_write_pkg::HDR_BITS - 1);
  assign line_end = hdr_done_reg &&
                    bit_cnt_reg == 8'(line_write_pkg::LINE_PIX_LAST);

  always_ff @(posedge sclk or posedge link_rst) begin
    if (link_rst)
      hdr_done_reg <= 1'b0;
    else if (hdr_end)
      hdr_done_reg <= 1'b1;
  end

  always_ff @(posedge sclk or posedge link_rst) begin
    if (link_rst)
      bit_cnt_reg <= 8'h00;
    else if (hdr_end)
      bit_cnt_reg <= 8'h00;
    else if (hdr_done_reg &&
             bit_cnt_reg == 8'(line_write_pkg::LINE_LAST))
      bit_cnt_reg <= 8'h00;
    else
      bit_cnt_reg <= bit_cnt_reg + 8'h01;
  end

  // Received mode flags survive the end of the frame for the system side
  logic update_rx_reg;
  logic polarity_rx_reg;
  logic clear_rx_reg;
  logic hdr_tgl_reg;
  logic hdr_bit;

  assign hdr_bit = chip_select_high && !hdr_done_reg;

  always_ff @(posedge sclk or posedge reset) begin
    if (reset)
      update_rx_reg <= 1'b0;
    else if (hdr_bit &&
             bit_cnt_reg == 8'(line_write_pkg::HDR_UPDATE_POS))
      update_rx_reg <= serial_data_in;
  end

  always_ff @(posedge sclk or posedge reset) begin
    if (reset)
      polarity_rx_reg <= 1'b0;
    else if (hdr_bit &&
             bit_cnt_reg == 8'(line_write_pkg::HDR_POLARITY_POS))
      polarity_rx_reg <= serial_data_in;
  end

  always_ff @(posedge sclk or posedge reset) begin
    if (reset)
      clear_rx_reg <= 1'b0;
    else if (hdr_bit &&
             bit_cnt_reg == 8'(line_write_pkg::HDR_CLEAR_POS))
      clear_rx_reg <= serial_data_in;
  end

  always_ff @(posedge sclk or posedge reset) begin
    if (reset)
      hdr_tgl_reg <= 1'b0;
    else if (chip_select_high && hdr_end)
      hdr_tgl_reg <= ~hdr_tgl_reg;
  end

  // Address and pixels shift in first bit first, landing in bit 0
  always_ff @(posedge sclk) begin
    if (chip_select_high && hdr_done_reg) begin
      if (bit_cnt_reg < 8'(line_write_pkg::ADDR_BITS))
        addr_sh_reg <= {serial_data_in, addr_sh_reg[7:1]};
      else if (bit_cnt_reg <= 8'(line_write_pkg::LINE_PIX_LAST))
        pix_sh_reg <= {serial_data_in, pix_sh_reg[PIXELS-1:1]};
    end
  end

  // Line latch: holds a full line while the next one shifts in, which
  // gives the system side a whole line time to copy it.
  logic [PIXELS-1:0] latch_pix_reg;
  logic [7:0] latch_addr_reg;
  logic line_tgl_reg;

  always_ff @(posedge sclk or posedge reset) begin
    if (reset) begin
      latch_pix_reg <= '0;
      latch_addr_reg <= 8'h00;
    end else if (chip_select_high && line_end) begin
      latch_pix_reg <= {serial_data_in, pix_sh_reg[PIXELS-1:1]};
      latch_addr_reg <= addr_sh_reg;
    end
  end

  always_ff @(posedge sclk or posedge reset) begin
    if (reset)
      line_tgl_reg <= 1'b0;
    else if (chip_select_high && line_end)
      line_tgl_reg <= ~line_tgl_reg;
  end

  // System domain
  // Link events cross as toggles, so a slow clk edge never loses one
  logic cs_s2, cs_d;
  logic src_s2;
  logic ext_s2, ext_d;
  logic hdr_s2, hdr_d;
  logic line_s2, line_d;

  sync_bit cs_sync (
    .clk(clk),
    .reset(reset),
    .din(chip_select_high),
    .dout(cs_s2)
  );

  sync_bit src_sync (
    .clk(clk),
    .reset(reset),
    .din(inversion_source_select),
    .dout(src_s2)
  );

  sync_bit ext_sync (
    .clk(clk),
    .reset(reset),
    .din(external_inversion_toggle),
    .dout(ext_s2)
  );

  sync_bit hdr_sync (
    .clk(clk),
    .reset(reset),
    .din(hdr_tgl_reg),
    .dout(hdr_s2)
  );

  sync_bit line_sync (
    .clk(clk),
    .reset(reset),
    .din(line_tgl_reg),
    .dout(line_s2)
  );

  // Delayed copies for edge detection on the synced levels
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cs_d <= 1'b0;
      ext_d <= 1'b0;
      hdr_d <= 1'b0;
      line_d <= 1'b0;
    end else begin
      cs_d <= cs_s2;
      ext_d <= ext_s2;
      hdr_d <= hdr_s2;
      line_d <= line_s2;
    end
  end

  logic frame_end;
  logic hdr_seen;
  logic line_seen;
  logic ext_rise;
  assign frame_end = cs_d & ~cs_s2;
  assign hdr_seen = hdr_s2 ^ hdr_d;
  assign line_seen = line_s2 ^ line_d;
  assign ext_rise = ext_s2 & ~ext_d;

  // A frame counts only if its whole mode header arrived
  logic frame_ok_reg;
  logic apply;
  assign apply = frame_end & frame_ok_reg;

  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      frame_ok_reg <= 1'b0;
    else if (hdr_seen)
      frame_ok_reg <= 1'b1;
    else if (frame_end)
      frame_ok_reg <= 1'b0;
  end

  // updating_mode is loaded only after the frame closes; the flags are stable then
  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      updating_mode <= line_write_pkg::MODE_RESET;
    else if (apply)
      updating_mode <= update_rx_reg;
  end

  // Clear-all walks one line per cycle instead of a single wide write
  logic [7:0] clr_idx_reg;
  logic clear_start;
  assign clear_start = apply && !update_rx_reg && clear_rx_reg;

  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      clear_busy <= 1'b0;
    else if (clear_start)
      clear_busy <= 1'b1;
    else if (clear_busy && clr_idx_reg == 8'(LINES - 1))
      clear_busy <= 1'b0;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      clr_idx_reg <= 8'h00;
    else if (clear_start)
      clr_idx_reg <= 8'h00;
    else if (clear_busy)
      clr_idx_reg <= clr_idx_reg + 8'h01;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      clear_done <= 1'b0;
    else if (clear_busy && clr_idx_reg == 8'(LINES - 1))
      clear_done <= 1'b1;
    else if (apply && !clear_rx_reg)
      clear_done <= 1'b0;
  end

  // Panel memory
  logic [PIXELS-1:0] mem [0:LINES-1];
  logic addr_ok;
  logic line_write;
  logic rd_ok;
  assign addr_ok = latch_addr_reg >= line_write_pkg::FIRST_LINE &&
                   latch_addr_reg <= line_write_pkg::LAST_LINE;
  assign line_write = line_seen && update_rx_reg && addr_ok;
  assign rd_ok = rd_line < 8'(LINES);

  // Clear wins over a line write landing in the same cycle
  always_ff @(posedge clk) begin
    if (clear_busy)
      mem[clr_idx_reg] <= {PIXELS{line_write_pkg::PIX_WHITE}};
    else if (line_write)
      mem[latch_addr_reg - 8'h01] <= latch_pix_reg;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      rd_pixels <= '0;
    else if (rd_ok)
      rd_pixels <= mem[rd_line];
  end

  // Inversion: software follows the flag, hardware follows the pin
  logic armed_reg;

  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      armed_reg <= 1'b0;
    else if (!src_s2)
      armed_reg <= 1'b0;
    else if (frame_end && armed_reg)
      armed_reg <= 1'b0;
    else if (ext_rise && cs_s2)
      armed_reg <= 1'b1;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      panel_inversion_level <= line_write_pkg::LEVEL_RESET;
    else if (!src_s2) begin
      if (apply)
        panel_inversion_level <= polarity_rx_reg;
    end else if (frame_end && armed_reg)
      panel_inversion_level <= ~panel_inversion_level;
    else if (ext_rise && !cs_s2)
      panel_inversion_level <= ~panel_inversion_level;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      internal_inversion_signal <= line_write_pkg::LEVEL_RESET;
    else
      internal_inversion_signal <= panel_inversion_level;
  end

endmodule : line_write_port

// Two-flop synchroniser for one level crossing into the clk domain
module sync_bit (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Level in and out
  input wire logic din,
  output logic dout
);

  // Only the second flop is seen outside, so no logic reads a metastable bit
  logic first_reg;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      first_reg <= 1'b0;
      dout <= 1'b0;
    end else begin
      first_reg <= din;
      dout <= first_reg;
    end
  end

endmodule : sync_bit

// file: hdl/line_write_pkg.sv
// Constants for the serial line-write port and its inversion control
package line_write_pkg;
  localparam int LINE_PIXELS = 144;
  localparam int LINE_COUNT = 168;
  localparam int ADDR_BITS = 8;
  localparam int HDR_BITS = 8;
  localparam int HDR_UPDATE_POS = 0;
  localparam int HDR_POLARITY_POS = 1;
  localparam int HDR_CLEAR_POS = 2;
  localparam int LINE_PIX_LAST = ADDR_BITS + LINE_PIXELS - 1;
  localparam int LINE_DUMMY_BITS = 8;
  localparam int LINE_LAST = LINE_PIX_LAST + LINE_DUMMY_BITS;
  localparam logic [7:0] FIRST_LINE = 8'h01;
  localparam logic [7:0] LAST_LINE = 8'ha8;
  localparam logic PIX_WHITE = 1'b1;
  localparam logic MODE_RESET = 1'b0;
  localparam logic LEVEL_RESET = 1'b0;
endpackage : line_write_pkg

// file: dv/line_write_monitor.sv
// Checker for the line-write port outputs
`timescale 1ns/10ps
module line_write_monitor #(parameter int PIXELS = 144) (
  // Watched ports
  input wire logic clk,
  input wire logic reset,
  input wire logic sclk,
  input wire logic chip_select_high,
  input wire logic serial_data_in,
  input wire logic inversion_source_select,
  input wire logic external_inversion_toggle,
  input wire logic [7:0] rd_line,
  input wire logic [PIXELS-1:0] rd_pixels,
  input wire logic updating_mode,
  input wire logic clear_busy,
  input wire logic clear_done,
  input wire logic panel_inversion_level,
  input wire logic internal_inversion_signal
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  logic [5:0] cs_hist_reg;
  logic apply_win;
  // Select is unsynced here, so the window spans the sync spread
  always_ff @(posedge clk or posedge reset)
    if (reset) cs_hist_reg <= 6'h00;
    else cs_hist_reg <= {cs_hist_reg[4:0], chip_select_high};
  assign apply_win = !chip_select_high && (|cs_hist_reg[5:2]);
  sequence walk_end;
    ##166 clear_busy ##[1:3] !clear_busy;
  endsequence
  a_walk_length:
    assert property ($rose(clear_busy) |-> walk_end)
    else $error("clear walk length wrong");
  a_done_at_end:
    assert property ($fell(clear_busy) |-> clear_done)
    else $error("clear done missing");
  a_clear_not_updating:
    assert property ($rose(clear_busy) |-> !updating_mode)
    else $error("clear started in updating mode");
  a_mode_at_apply:
    assert property ($changed(updating_mode) |-> apply_win)
    else $error("mode changed outside frame end");
  a_level_at_apply:
    assert property (!inversion_source_select
      && $changed(panel_inversion_level) |-> apply_win)
    else $error("soft level changed outside frame end");
  a_ext_idle_flip:
    assert property (inversion_source_select && !chip_select_high
      && $rose(external_inversion_toggle)
      |-> ##[2:4] $changed(panel_inversion_level))
    else $error("idle external rise did not flip level");
  a_armed_hold:
    assert property ((inversion_source_select && chip_select_high)[*6]
      |-> $stable(panel_inversion_level))
    else $error("level moved while select high");
  a_internal_lag:
    assert property ($changed(panel_inversion_level)
      |=> internal_inversion_signal == $past(panel_inversion_level))
    else $error("internal signal not one clock behind");
endmodule : line_write_monitor

// file: dv/host_link_model.sv
// Host model driving frames on the serial link
`timescale 1ns/10ps
module host_link_model (
  // Serial link
  output logic sclk,
  output logic chip_select_high,
  output logic serial_data_in
);
  initial begin
    sclk = 1'b0;
    chip_select_high = 1'b0;
    serial_data_in = 1'b0;
  end
  // 12 ns link clock, parked low outside frames
  task automatic put(input logic b);
    serial_data_in = b;
    #6 sclk = 1'b1;
    #6 sclk = 1'b0;
  endtask : put
  task automatic frame(input logic [7:0] hdr, input logic [7:0] adr,
      input logic [143:0] pix, input int n, input logic dmy);
    chip_select_high = 1'b1;
    #100;
    for (int i = 0; i < 8; i++) put(hdr[i]);
    for (int l = 0; l < n; l++) begin
      for (int i = 0; i < 8; i++) put(adr[i]);
      for (int i = 0; i < 144; i++) put(pix[i]);
      for (int i = 0; i < 8; i++) put(dmy);
      adr = adr + 8'h01;
    end
    #100;
    chip_select_high = 1'b0;
    // A released line must not pass for a held bit
    serial_data_in = ~serial_data_in;
    #1200;
  endtask : frame
endmodule : host_link_model

// file: dv/testbench.sv
// Self-checking bench for the line-write port
`timescale 1ns/10ps
module testbench;
  logic clk, reset, src, ext, sclk, cs, sdi, upd, busy, done, lvl, icom;
  logic [7:0] rd_line;
  logic [143:0] rd_pixels;
  int failures;
  int compares;
  localparam logic [143:0] PA = {9{16'ha5c3}};
  localparam logic [143:0] PB = {18{8'h0f}};
  localparam logic [143:0] WH = {144{1'b1}};
  line_write_port uut (.clk(clk), .reset(reset), .sclk(sclk),
    .chip_select_high(cs), .serial_data_in(sdi),
    .inversion_source_select(src), .external_inversion_toggle(ext),
    .rd_line(rd_line), .rd_pixels(rd_pixels), .updating_mode(upd),
    .clear_busy(busy), .clear_done(done), .panel_inversion_level(lvl),
    .internal_inversion_signal(icom));
  host_link_model host (.sclk(sclk), .chip_select_high(cs),
    .serial_data_in(sdi));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic check(input logic [143:0] got, input logic [143:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check
  task automatic bit_is(input logic got, input logic exp);
    check({143'h0, got}, {143'h0, exp});
  endtask : bit_is
  task automatic rd(input logic [7:0] l, input logic [143:0] exp);
    @(posedge clk);
    rd_line <= l;
    repeat (2) @(posedge clk);
    #1 check(rd_pixels, exp);
  endtask : rd
  task automatic final_report();
    if (failures == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report
  initial begin
    #2000000;
    failures++;
    final_report();
  end
  initial begin
    reset = 1'b1;
    src = 1'b0;
    ext = 1'b0;
    rd_line = 8'h00;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    host.frame(8'h04, 8'h00, PA, 0, 1'b0);
    for (int i = 0; i < 400 && done !== 1'b1; i++) @(posedge clk);
    #1 bit_is(busy, 1'b0);
    rd(8'ha7, WH);
    host.frame(8'h03, 8'h00, PA, 2, 1'b0);
    bit_is(upd, 1'b1);
    bit_is(done, 1'b0);
    bit_is(lvl, 1'b1);
    bit_is(icom, 1'b1);
    rd(8'h00, PA);
    rd(8'h01, WH);
    host.frame(8'h01, 8'ha7, PB, 2, 1'b1);
    bit_is(lvl, 1'b0);
    rd(8'ha6, PB);
    rd(8'ha7, PB);
    host.frame(8'h02, 8'h02, PB, 1, 1'b0);
    bit_is(upd, 1'b0);
    rd(8'h01, WH);
    @(posedge clk);
    src <= 1'b1;
    host.frame(8'h00, 8'h00, PA, 0, 1'b0);
    bit_is(lvl, 1'b1);
    @(posedge clk);
    ext <= 1'b1;
    repeat (5) @(posedge clk);
    #1 bit_is(lvl, 1'b0);
    @(posedge clk);
    ext <= 1'b0;
    fork
      host.frame(8'h02, 8'h00, PA, 1, 1'b0);
      begin
        repeat (4) @(posedge clk);
        ext <= 1'b1;
        repeat (20) @(posedge clk);
        #1 bit_is(lvl, 1'b0);
      end
    join
    bit_is(lvl, 1'b1);
    final_report();
  end
endmodule : testbench
bind line_write_port line_write_monitor #(.PIXELS(PIXELS)) mon (.*);
